// >>> tdm_pkg.sv
// tdm_pkg: shared constants for the totalizer and parallel port module
package tdm_pkg;
    // system clock and counted-input rate
    localparam int CLK_HZ = 25_000_000;
    localparam int TOT_RATE_HZ = 100_000;
    // shortest input period at the top rate, in clocks
    localparam int TOT_PERIOD_CYC = CLK_HZ / TOT_RATE_HZ;
    // synchroniser depth for the totalizer pin inputs; port pins are not synchronised
    localparam int SYNC_STAGES = 2;
    // field widths
    localparam int CNT_W = 26;
    localparam int PORT_W = 8;
    localparam int DAC_W = 16;
    localparam int CHAN_W = 7;
    localparam int SLOT_W = 9;
    // counter limits and reset values
    localparam logic [CNT_W-1:0] CNT_MAX = 26'h3ffffff;
    localparam logic [CNT_W-1:0] CNT_RST = 26'h0000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 26'h0000001;
    localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
    // mid-scale code, near zero volts on the bipolar output
    localparam logic [DAC_W-1:0] DAC_RST = 16'h8000;
    // channel numbers within the module
    localparam logic [CHAN_W-1:0] CH_PORT1 = 7'h01;
    localparam logic [CHAN_W-1:0] CH_PORT2 = 7'h02;
    localparam logic [CHAN_W-1:0] CH_TOT = 7'h03;
    localparam logic [CHAN_W-1:0] CH_DAC1 = 7'h04;
    localparam logic [CHAN_W-1:0] CH_DAC2 = 7'h05;
    // slot numbers used by the controller
    localparam logic [SLOT_W-1:0] SLOT_1 = 9'h064;
    localparam logic [SLOT_W-1:0] SLOT_2 = 9'h0c8;
    localparam logic [SLOT_W-1:0] SLOT_3 = 9'h12c;
endpackage : tdm_pkg

// >>> tdm_sync.sv
// tdm_sync: one-bit multi-stage synchroniser
`timescale 1ns/1ns
`default_nettype none
module tdm_sync #(
    parameter int STAGES = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // level in and synchronised level out
    input wire logic d_in,
    output logic q_out
);
    logic [STAGES-1:0] sh_ff;
    logic [STAGES-1:0] nxt_sh;

    // first stage feeds only the next stage
    always_comb
    begin
        nxt_sh = {sh_ff[STAGES-2:0], d_in};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            sh_ff <= '0;
        else
            sh_ff <= nxt_sh;
    end

    assign q_out = sh_ff[STAGES-1];
endmodule : tdm_sync
`default_nettype wire

// >>> tdm_core.sv
// tdm_core: pulse totalizer, two parallel ports and two analog codes
//
// Overview of operation
// - 26-bit counter adds one per qualifying edge, inputs up to 100 kHz.
// - configuration picks rising or falling edge of the counted input.
// - active-high gate enables counting while high, holds while low.
// - active-low gate enables counting while low, holds while high.
// - count advances only when both gates enable; otherwise held.
// - count reaches all-ones 26-bit maximum, the largest value read back.
// - two independent 8-bit ports, each usable as input or output.
// - combined 16-bit read only when neither port is in the scan list.
// - front-panel reads return one 8-bit port, never both.
// - ports and count may be sampled as scan channels.
// - each of two analog channels holds a 16-bit output code.
// - count read keeps count, or read_then_clear returns then zeroes (sets one if an edge counts in that cycle).
`timescale 1ns/1ns
`default_nettype none
module tdm_core #(
    parameter logic [tdm_pkg::SLOT_W-1:0] SLOT_NUM = tdm_pkg::SLOT_1,
    parameter int SYNC_STAGES = tdm_pkg::SYNC_STAGES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // totalizer pins
    input wire logic tot_in,
    input wire logic tot_gate_hi,
    input wire logic tot_gate_lo_b,
    // configuration and scan membership
    input wire logic tot_edge_falling,
    input wire logic [1:0] port_dir_out,
    input wire logic [1:0] port_in_scan,
    // parallel_port_pair pins, open drain
    input wire logic [2*tdm_pkg::PORT_W-1:0] pp_pin_in,
    output logic [2*tdm_pkg::PORT_W-1:0] pp_pin_out,
    output logic [2*tdm_pkg::PORT_W-1:0] pp_pin_oe,
    // controller requests
    input wire logic req_stb,
    input wire logic [tdm_pkg::SLOT_W-1:0] req_slot,
    input wire logic [tdm_pkg::CHAN_W-1:0] req_chan,
    input wire logic req_write,
    input wire logic [tdm_pkg::DAC_W-1:0] req_wdata,
    input wire logic req_word,
    input wire logic req_clear,
    input wire logic req_front,
    input wire logic req_scan,
    // answers
    output logic rsp_valid,
    output logic rsp_err,
    output logic [tdm_pkg::CNT_W-1:0] rsp_data,
    // held values
    output logic [tdm_pkg::DAC_W-1:0] dac1_code,
    output logic [tdm_pkg::DAC_W-1:0] dac2_code,
    output logic [tdm_pkg::CNT_W-1:0] tot_count
);
    localparam int PW = tdm_pkg::PORT_W;
    localparam int CW = tdm_pkg::CNT_W;

    function automatic logic is_port(input logic [tdm_pkg::CHAN_W-1:0] ch);
        is_port = (ch == tdm_pkg::CH_PORT1) || (ch == tdm_pkg::CH_PORT2);
    endfunction : is_port

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [2:0] raw_in;
    logic [2:0] sync_out;
    logic cnt_s;
    logic ghi_s;
    logic glo_s;

    assign raw_in = {tot_gate_lo_b, tot_gate_hi, tot_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            tdm_sync #(.STAGES(SYNC_STAGES)) u_sync (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .d_in(raw_in[gi]),
                .q_out(sync_out[gi])
            );
        end
    endgenerate

    assign cnt_s = sync_out[0];
    assign ghi_s = sync_out[1];
    assign glo_s = sync_out[2];

    ////////////////////////////////////////////////////////////////////////
    // totalizer
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic cnt_prev_ff;
    logic nxt_cnt_prev;
    logic cnt_edge;
    logic cnt_qual;
    logic cnt_inc;
    logic tot_clr;

    always_comb
    begin
        nxt_cnt_prev = cnt_s;
        // edge seen on the synchronised copy only
        cnt_edge = tot_edge_falling ? (cnt_prev_ff & ~cnt_s)
                                    : (cnt_s & ~cnt_prev_ff);
        cnt_qual = ghi_s & ~glo_s;
        cnt_inc = cnt_edge & cnt_qual;
        nxt_cnt = cnt_ff;
        if (tot_clr)
            nxt_cnt = cnt_inc ? tdm_pkg::CNT_ONE : tdm_pkg::CNT_RST;
        else if (cnt_inc)
            if (cnt_ff == tdm_pkg::CNT_MAX)
                nxt_cnt = tdm_pkg::CNT_RST;
            else
                nxt_cnt = cnt_ff + tdm_pkg::CNT_ONE;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cnt_ff <= tdm_pkg::CNT_RST;
            cnt_prev_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            cnt_prev_ff <= nxt_cnt_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request decode and answers
    logic req_hit;
    logic rsp_valid_ff;
    logic rsp_err_ff;
    logic [CW-1:0] rsp_data_ff;
    logic nxt_rsp_valid;
    logic nxt_rsp_err;
    logic [CW-1:0] nxt_rsp_data;
    logic wr_port1;
    logic wr_port2;
    logic wr_dac1;
    logic wr_dac2;
    logic [PW-1:0] port1_ff;
    logic [PW-1:0] port2_ff;
    logic [2*PW-1:0] oe_ff;
    logic [tdm_pkg::DAC_W-1:0] dac1_ff;
    logic [tdm_pkg::DAC_W-1:0] dac2_ff;
    logic [PW-1:0] nxt_port1;
    logic [PW-1:0] nxt_port2;
    logic [2*PW-1:0] nxt_oe;
    logic [tdm_pkg::DAC_W-1:0] nxt_dac1;
    logic [tdm_pkg::DAC_W-1:0] nxt_dac2;

    // other slots are not ours; they get no answer at all
    assign req_hit = req_stb && (req_slot == SLOT_NUM);

    always_comb
    begin
        nxt_rsp_valid = req_hit;
        nxt_rsp_err = 1'b0;
        nxt_rsp_data = tdm_pkg::CNT_RST;
        tot_clr = 1'b0;
        wr_port1 = 1'b0;
        wr_port2 = 1'b0;
        wr_dac1 = 1'b0;
        wr_dac2 = 1'b0;
        if (req_hit)
        begin
            if (req_word)
            begin
                // word read blocks while scanning, and from the panel
                if (req_write || req_scan || req_front || (|port_in_scan)
                    || req_chan != tdm_pkg::CH_PORT1)
                    nxt_rsp_err = 1'b1;
                else
                    nxt_rsp_data = {{(CW-2*PW){1'b0}}, pp_pin_in};
            end
            else
            begin
                case (req_chan)
                    tdm_pkg::CH_PORT1:
                        if (req_write && req_scan)
                            nxt_rsp_err = 1'b1;
                        else if (req_write)
                            wr_port1 = 1'b1;
                        else
                            nxt_rsp_data = {{(CW-PW){1'b0}},
                                            pp_pin_in[PW-1:0]};
                    tdm_pkg::CH_PORT2:
                        if (req_write && req_scan)
                            nxt_rsp_err = 1'b1;
                        else if (req_write)
                            wr_port2 = 1'b1;
                        else
                            nxt_rsp_data = {{(CW-PW){1'b0}},
                                            pp_pin_in[2*PW-1:PW]};
                    tdm_pkg::CH_TOT:
                        if (req_write)
                            nxt_rsp_err = 1'b1;
                        else
                        begin
                            nxt_rsp_data = cnt_ff;
                            tot_clr = req_clear;
                        end
                    tdm_pkg::CH_DAC1:
                        if (req_scan)
                            nxt_rsp_err = 1'b1;
                        else if (req_write)
                            wr_dac1 = 1'b1;
                        else
                            nxt_rsp_data = {{(CW-16){1'b0}}, dac1_ff};
                    tdm_pkg::CH_DAC2:
                        if (req_scan)
                            nxt_rsp_err = 1'b1;
                        else if (req_write)
                            wr_dac2 = 1'b1;
                        else
                            nxt_rsp_data = {{(CW-16){1'b0}}, dac2_ff};
                    default:
                        nxt_rsp_err = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_err_ff <= 1'b0;
            rsp_data_ff <= tdm_pkg::CNT_RST;
        end
        else
        begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_err_ff <= nxt_rsp_err;
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port data and analog codes
    always_comb
    begin
        nxt_port1 = wr_port1 ? req_wdata[PW-1:0] : port1_ff;
        nxt_port2 = wr_port2 ? req_wdata[PW-1:0] : port2_ff;
        // open drain: sink only the zero bits of an output port
        nxt_oe = {~nxt_port2 & {PW{port_dir_out[1]}},
                  ~nxt_port1 & {PW{port_dir_out[0]}}};
        nxt_dac1 = wr_dac1 ? req_wdata : dac1_ff;
        nxt_dac2 = wr_dac2 ? req_wdata : dac2_ff;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            port1_ff <= tdm_pkg::PORT_RST;
            port2_ff <= tdm_pkg::PORT_RST;
            oe_ff <= '0;
            dac1_ff <= tdm_pkg::DAC_RST;
            dac2_ff <= tdm_pkg::DAC_RST;
        end
        else
        begin
            port1_ff <= nxt_port1;
            port2_ff <= nxt_port2;
            oe_ff <= nxt_oe;
            dac1_ff <= nxt_dac1;
            dac2_ff <= nxt_dac2;
        end
    end

    assign pp_pin_out = {port2_ff, port1_ff};
    assign pp_pin_oe = oe_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_err = rsp_err_ff;
    assign rsp_data = rsp_data_ff;
    assign dac1_code = dac1_ff;
    assign dac2_code = dac2_ff;
    assign tot_count = cnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_clear_read;
        req_hit && !req_word && !req_write && req_chan == tdm_pkg::CH_TOT
            && req_clear;
    endsequence

    sequence s_clear_done;
        rsp_valid_ff && !rsp_err_ff && cnt_ff <= tdm_pkg::CNT_ONE;
    endsequence

    AST_CNT_INC: assert property (
        cnt_inc && !tot_clr && cnt_ff != tdm_pkg::CNT_MAX
        |=> cnt_ff == $past(cnt_ff) + tdm_pkg::CNT_ONE)
        else $error("count did not advance on a qualified edge");

    AST_EDGE_SEL: assert property (
        tot_edge_falling && cnt_s && !cnt_prev_ff && !tot_clr
        |=> $stable(cnt_ff))
        else $error("rising edge counted in falling mode");

    AST_GATE_HI: assert property (
        !ghi_s && !tot_clr |=> $stable(cnt_ff))
        else $error("count moved with high gate low");

    AST_GATE_LO: assert property (
        glo_s && !tot_clr |=> $stable(cnt_ff))
        else $error("count moved with low gate high");

    AST_BOTH_GATES: assert property (
        !tot_clr ##1 cnt_ff != $past(cnt_ff) |-> $past(ghi_s && !glo_s))
        else $error("count moved without both gates enabled");

    AST_WRAP: assert property (
        cnt_inc && !tot_clr && cnt_ff == tdm_pkg::CNT_MAX
        |=> cnt_ff == tdm_pkg::CNT_RST)
        else $error("count did not wrap to zero");

    AST_CLEAR: assert property (
        s_clear_read |=> s_clear_done ##0 rsp_data_ff == $past(cnt_ff))
        else $error("read_then_clear wrong value or count not cleared");

    AST_WORD_SCAN: assert property (
        req_hit && req_word && (|port_in_scan) |=> rsp_valid_ff && rsp_err_ff)
        else $error("word read allowed while a port is scanned");

    AST_FRONT: assert property (
        req_hit && req_front && !req_write && is_port(req_chan)
        |=> rsp_err_ff || rsp_data_ff[CW-1:PW] == '0)
        else $error("front panel read returned more than one port");

    AST_SCAN: assert property (
        req_hit && req_scan && !req_write && !req_word
        && (is_port(req_chan) || req_chan == tdm_pkg::CH_TOT)
        |=> rsp_valid_ff && !rsp_err_ff)
        else $error("scan sample of port or count refused");

    AST_DAC: assert property (
        req_hit && req_write && !req_word && !req_scan
        && req_chan == tdm_pkg::CH_DAC1 |=> dac1_code == $past(req_wdata))
        else $error("analog code not stored");

    AST_SYNC: assert property (
        $rose(cnt_s) |-> $past(tot_in, SYNC_STAGES))
        else $error("counted input used before synchronising");

    AST_SLOT: assert property (
        !req_hit |=> !rsp_valid_ff)
        else $error("answer given for another slot");
endmodule : tdm_core
`default_nettype wire

// >>> tdm_far.sv
// tdm_far: far-side lines, open-drain pins with pull-ups and pulse source
`timescale 1ns/1ns
`default_nettype none
module tdm_far (
    // clock
    input wire logic clk_sys,
    // pin lines
    input wire logic [15:0] pp_pin_oe,
    input wire logic [15:0] ext_drive,
    output logic [15:0] pp_pin_in,
    // counted input
    output logic tot_in
);
    // pull-up wins unless some party sinks the line
    assign pp_pin_in = ext_drive & ~pp_pin_oe;
    initial tot_in = 1'b0;
    // each level held 4 clocks, far faster than the 100 kHz top rate
    task automatic drive_tot(input logic v);
        @(posedge clk_sys);
        #1;
        tot_in = v;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : drive_tot
endmodule : tdm_far
`default_nettype wire

// >>> testbench.sv
// testbench: self-checking bench for tdm_core with a behavioural model
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic tot_in, gate_hi = 1'b1, gate_lo_b = 1'b0, edge_f = 1'b0;
    logic [1:0] dir = 2'h0, in_scan = 2'h0;
    logic [15:0] ext = 16'hffff, pin_in, pin_out, pin_oe, dac1, dac2;
    logic stb = 1'b0, wr = 1'b0, word = 1'b0, clr = 1'b0;
    logic front = 1'b0, scan = 1'b0, rsp_valid, rsp_err, err_seen;
    logic [8:0] slot = tdm_pkg::SLOT_1;
    logic [6:0] chan = 7'h01, c;
    logic [15:0] wdata = 16'h0000, v, exp_pd, exp_oe, exp_pin;
    logic [25:0] rsp_data, tot_count, got;
    logic [15:0] exp_dac [2];
    logic [13:0] bad [7];
    logic w;
    logic [3:0] f;
    int n_fail = 0;
    int comparisons = 0;
    int exp_cnt = 0;
    int k, n;

    always #20 clk_sys = ~clk_sys;

    tdm_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .tot_in(tot_in),
        .tot_gate_hi(gate_hi), .tot_gate_lo_b(gate_lo_b),
        .tot_edge_falling(edge_f), .port_dir_out(dir),
        .port_in_scan(in_scan), .pp_pin_in(pin_in), .pp_pin_out(pin_out),
        .pp_pin_oe(pin_oe), .req_stb(stb), .req_slot(slot),
        .req_chan(chan), .req_write(wr), .req_wdata(wdata),
        .req_word(word), .req_clear(clr), .req_front(front),
        .req_scan(scan), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_data(rsp_data), .dac1_code(dac1), .dac2_code(dac2),
        .tot_count(tot_count));

    tdm_far far (.clk_sys(clk_sys), .pp_pin_oe(pin_oe), .ext_drive(ext),
        .pp_pin_in(pin_in), .tot_in(tot_in));

    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("counts: %0d compared, %0d failed", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic check(input logic [25:0] seen, input logic [25:0] exp,
        input string what);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen,
                exp);
        end
    endtask : check

    // flags are {word, clear, front, scan}
    task automatic req(input logic [6:0] ch, input logic wrt,
        input logic [15:0] d, input logic [3:0] fl, input logic ans);
        int i;
        @(posedge clk_sys);
        #1;
        stb = 1'b1;
        chan = ch;
        wr = wrt;
        wdata = d;
        word = fl[3];
        clr = fl[2];
        front = fl[1];
        scan = fl[0];
        @(posedge clk_sys);
        #1;
        stb = 1'b0;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 3)
        begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        got = rsp_data;
        err_seen = rsp_err;
        check(26'(i < 3), 26'(ans), "answer presence");
        if (ans && i == 3)
            final_report();
    endtask : req

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h684d99c2));
        repeat (4) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        check(26'(dac1), 26'(tdm_pkg::DAC_RST), "dac1 reset");
        check(tot_count, 26'h0, "count reset");
        check(26'(pin_out | pin_oe), 26'h0, "pins reset");
        $display("test reset done");
        for (k = 0; k < 4; k++)
        begin
            v = 16'($urandom);
            exp_dac[k % 2] = v;
            req(7'h04 + 7'(k % 2), 1'b1, v, 4'h0, 1'b1);
            check(26'(err_seen), 26'h0, "dac write err");
            check(got, 26'h0, "dac write data");
            check(26'(k % 2 ? dac2 : dac1), 26'(v), "dac code");
        end
        slot = $urandom_range(1, 0) ? tdm_pkg::SLOT_2 : tdm_pkg::SLOT_3;
        req(7'h04, 1'b1, ~exp_dac[0], 4'h0, 1'b0);
        check(26'(dac1), 26'(exp_dac[0]), "other slot");
        slot = tdm_pkg::SLOT_1;
        req(7'h04, 1'b0, 16'h0000, 4'h0, 1'b1);
        check(got, 26'(exp_dac[0]), "dac1 read");
        $display("test dac done");
        dir = 2'($urandom);
        ext = 16'($urandom);
        for (k = 0; k < 2; k++)
        begin
            v = 16'($urandom) & 16'h00ff;
            req(7'h01 + 7'(k), 1'b1, v, 4'h0, 1'b1);
            exp_pd[k * 8 +: 8] = v[7:0];
        end
        exp_oe = {{8{dir[1]}} & ~exp_pd[15:8], {8{dir[0]}} & ~exp_pd[7:0]};
        exp_pin = ext & ~exp_oe;
        check(26'(pin_out), 26'(exp_pd), "port data");
        check(26'(pin_oe), 26'(exp_oe), "port sink");
        req(7'h01, 1'b0, 16'h0000, 4'h0, 1'b1);
        check(got, 26'(exp_pin[7:0]), "port1 read");
        req(7'h02, 1'b0, 16'h0000, 4'h2, 1'b1);
        check(got, 26'(exp_pin[15:8]), "front read");
        req(7'h01, 1'b0, 16'h0000, 4'h8, 1'b1);
        check(26'(err_seen), 26'h0, "word err");
        check(got, 26'(exp_pin), "word read");
        req(7'h01, 1'b0, 16'h0000, 4'h1, 1'b1);
        check(26'(err_seen), 26'h0, "scan port err");
        check(got, 26'(exp_pin[7:0]), "scan port");
        // refused cases: {scan list, chan, write, flags}
        bad = '{{2'h1, 7'h01, 1'b0, 4'h8}, {2'h2, 7'h01, 1'b0, 4'h8},
            {2'h0, 7'h01, 1'b0, 4'ha}, {2'h0, 7'h03, 1'b1, 4'h0},
            {2'h0, 7'h04, 1'b0, 4'h1}, {2'h0, 7'h06, 1'b0, 4'h0},
            {2'h0, 7'h02, 1'b1, 4'h1}};
        for (k = 0; k < 7; k++)
        begin
            in_scan = bad[k][13:12];
            c = bad[k][11:5];
            w = bad[k][4];
            f = bad[k][3:0];
            req(c, w, 16'h0000, f, 1'b1);
            check(26'(err_seen), 26'h1, "refusal");
            check(got, 26'h0, "refused data");
        end
        in_scan = 2'h0;
        $display("test ports done");
        n = $urandom_range(8, 3);
        for (k = 0; k < n; k++)
        begin
            far.drive_tot(1'b1);
            exp_cnt++;
            check(tot_count, 26'(exp_cnt), "rising count");
            far.drive_tot(1'b0);
            check(tot_count, 26'(exp_cnt), "fall ignored");
        end
        edge_f = 1'b1;
        far.drive_tot(1'b1);
        check(tot_count, 26'(exp_cnt), "rise ignored");
        far.drive_tot(1'b0);
        exp_cnt++;
        check(tot_count, 26'(exp_cnt), "falling count");
        // every gate pair but the enabling one must hold the count
        for (k = 0; k < 3; k++)
        begin
            gate_hi = (k == 2);
            gate_lo_b = (k != 0);
            far.drive_tot(1'b1);
            far.drive_tot(1'b0);
            check(tot_count, 26'(exp_cnt), "gated off");
        end
        gate_hi = 1'b1;
        gate_lo_b = 1'b0;
        $display("test count done");
        req(7'h03, 1'b0, 16'h0000, 4'h0, 1'b1);
        check(got, 26'(exp_cnt), "count read");
        req(7'h03, 1'b0, 16'h0000, 4'h1, 1'b1);
        check(got, 26'(exp_cnt), "scan count");
        req(7'h03, 1'b0, 16'h0000, 4'h4, 1'b1);
        check(got, 26'(exp_cnt), "clear read");
        exp_cnt = 0;
        check(tot_count, 26'(exp_cnt), "cleared");
        $display("test read done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
